// file: cca_mode_ctrl.sv
// Counter array mode control: three capture/compare modules, counter and APB registers
`timescale 1ns/1ps
`default_nettype none
module cca_mode_ctrl (
   input wire logic core_clk,
   input wire logic rstn,
   input wire cca_pkg::cca_apb_req_s apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [cca_pkg::NMOD-1:0] edgeIn,
   output logic [cca_pkg::NMOD-1:0] moduleOutputPin,
   output logic irq,
   output logic wdtExpire
);
   import cca_pkg::*;

   // *************************************************************
   // State
   // *************************************************************
   cca_mode_s [NMOD-1:0] mode_reg;
   logic [NMOD-1:0][15:0] cmp_reg;
   logic [15:0] cnt_reg;
   logic [7:0] snap_reg;
   logic [7:0] ctrl_reg;
   logic [1:0] cycle_length_select_reg;
   logic [NMOD-1:0] ccf_reg, ccf_next;
   logic [NMOD-1:0] pin_reg, matchPrev_reg;
   logic wdPrev_reg, irq_reg, wdt_reg;
   logic [31:0] prdata_reg;
   logic pready_reg, pslverr_reg;
   logic [NMOD-1:0] riseEv, fallEv, capEv, matchEv, eqSel, freqMode, pwmLevel, active;
   logic [31:0] rdData;
   logic rdErr, setupPh, accessPh, wrEv, wdOn, cntRun, wdHit;
   logic [7:0] idx, wd8;

   // *************************************************************
   // Helpers
   // *************************************************************
   // Cycle mask: full for 16-bit, else 8..11 low bits by code
   function automatic logic [15:0] cycMask(input logic wide, input logic [1:0] sel);
      cycMask = wide ? FULL_MASK : ((BASE_MASK << sel) | BASE_MASK);
   endfunction

   // True for writes that software may not make to this module's mode
   function automatic logic modeLocked(input int n, input logic wd);
      modeLocked = wd && (n == WDOG_MODULE);
   endfunction

   // *************************************************************
   // Pin synchronisation
   // *************************************************************
   // Edge pulses come three cycles late; captures see that latency
   cca_edge_sync #(.W(NMOD)) uSync (
      .clk(core_clk),
      .rstn(rstn),
      .din(edgeIn),
      .rise(riseEv),
      .fall(fallEv)
   );

   // *************************************************************
   // APB decode
   // *************************************************************
   // Zero wait: answer is prepared in setup, pready high in access
   assign idx = apbReq.paddr[9:2];
   assign wd8 = apbReq.pwdata[7:0];
   assign setupPh = apbReq.psel & ~apbReq.penable;
   assign accessPh = apbReq.psel & apbReq.penable & pready_reg;
   assign wrEv = accessPh & apbReq.pwrite;
   assign wdOn = ctrl_reg[CTRL_WATCHDOG_ENABLE_BIT_BIT];
   assign cntRun = ctrl_reg[CTRL_RUN_BIT];

   // Read mux; unmapped index answers zero with an error
   always_comb begin
      rdData = '0;
      rdErr = 1'b1;
      for (int n = 0; n < NMOD; n++) begin
         if (idx == IDX_MODE[n]) begin
            rdData[7:0] = mode_reg[n];
            rdErr = 1'b0;
         end
         if (idx == IDX_CMPL[n]) begin
            rdData[7:0] = cmp_reg[n][7:0];
            rdErr = 1'b0;
         end
         if (idx == IDX_CMPH[n]) begin
            rdData[7:0] = cmp_reg[n][15:8];
            rdErr = 1'b0;
         end
      end
      case (idx)
         IDX_CNTL: begin
            rdData[7:0] = cnt_reg[7:0];
            rdErr = 1'b0;
         end
         IDX_CNTH: begin
            rdData[7:0] = snap_reg;
            rdErr = 1'b0;
         end
         IDX_PWMCFG: begin
            rdData[1:0] = cycle_length_select_reg;
            rdErr = 1'b0;
         end
         IDX_CTRL: begin
            rdData[7:0] = ctrl_reg;
            rdErr = 1'b0;
         end
         IDX_STAT: begin
            rdData[NMOD-1:0] = ccf_reg;
            rdErr = 1'b0;
         end
         IDX_MASK: begin
            for (int n = 0; n < NMOD; n++) begin
               rdData[n] = mode_reg[n].flagIrqEnable;
            end
            rdErr = 1'b0;
         end
         default: begin
         end
      endcase
   end

   // Bus answer registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setupPh;
         if (setupPh) begin
            prdata_reg <= apbReq.pwrite ? 32'h0000_0000 : rdData;
            pslverr_reg <= rdErr;
         end
      end
   end

   // *************************************************************
   // Module compare and capture decode
   // *************************************************************
   // Module two under watchdog runs none of its normal functions
   always_comb begin
      for (int n = 0; n < NMOD; n++) begin
         active[n] = !modeLocked(n, wdOn);
         freqMode[n] = mode_reg[n].toggleEnable & mode_reg[n].pulseModEnable;
         eqSel[n] = freqMode[n] ? (cnt_reg[7:0] == cmp_reg[n][7:0]) : (cnt_reg == cmp_reg[n]);
         matchEv[n] = active[n] & mode_reg[n].compareEnable & eqSel[n] & ~matchPrev_reg[n];
         capEv[n] = active[n] & ((riseEv[n] & mode_reg[n].riseCaptureEnable)
                    | (fallEv[n] & mode_reg[n].fallCaptureEnable));
         pwmLevel[n] = (cnt_reg & cycMask(mode_reg[n].wideCycleSelect, cycle_length_select_reg))
                       >= (cmp_reg[n] & cycMask(mode_reg[n].wideCycleSelect, cycle_length_select_reg));
      end
   end

   // Match seen once per arrival, so a stopped counter fires once
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         matchPrev_reg <= '0;
      end else begin
         matchPrev_reg <= eqSel;
      end
   end

   // *************************************************************
   // Counter and snapshot
   // *************************************************************
   // Software write beats the increment in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= CNT_RST;
      end else if (wrEv && idx == IDX_CNTL && !wdOn) begin
         cnt_reg[7:0] <= wd8;
      end else if (wrEv && idx == IDX_CNTH && !wdOn) begin
         cnt_reg[15:8] <= wd8;
      end else if (cntRun) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // High byte frozen at the low-byte read so two reads stay coherent
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         snap_reg <= 8'h00;
      end else if (setupPh && !apbReq.pwrite && idx == IDX_CNTL) begin
         snap_reg <= cnt_reg[15:8];
      end
   end

   // *************************************************************
   // Control registers
   // *************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= CTRL_RST;
         cycle_length_select_reg <= CYCLE_LENGTH_SELECT_RST;
      end else if (wrEv) begin
         if (idx == IDX_CTRL) begin
            ctrl_reg <= wd8;
         end
         if (idx == IDX_PWMCFG) begin
            cycle_length_select_reg <= wd8[1:0];
         end
      end
   end

   // Mode registers with compare-byte side effects on compare enable
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_reg <= {NMOD{MODE_RST}};
      end else if (wrEv) begin
         for (int n = 0; n < NMOD; n++) begin
            if (!modeLocked(n, wdOn)) begin
               if (idx == IDX_MODE[n]) begin
                  mode_reg[n] <= wd8;
               end
               if (idx == IDX_MASK) begin
                  mode_reg[n].flagIrqEnable <= wd8[n];
               end
               if (idx == IDX_CMPL[n]) begin
                  mode_reg[n].compareEnable <= 1'b0;
               end
               if (idx == IDX_CMPH[n]) begin
                  mode_reg[n].compareEnable <= 1'b1;
               end
            end
         end
      end
   end

   // *************************************************************
   // Compare registers
   // *************************************************************
   // Capture outranks a same-cycle software write
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cmp_reg <= {NMOD{CMP_RST}};
      end else begin
         for (int n = 0; n < NMOD; n++) begin
            if (capEv[n]) begin
               cmp_reg[n] <= cnt_reg;
            end else if (matchEv[n] && freqMode[n]) begin
               cmp_reg[n][7:0] <= cmp_reg[n][7:0] + cmp_reg[n][15:8];
            end else if (wrEv && idx == IDX_CMPL[n]) begin
               cmp_reg[n][7:0] <= wd8;
            end else if (wrEv && idx == IDX_CMPH[n]) begin
               cmp_reg[n][15:8] <= wd8;
            end
         end
      end
   end

   // *************************************************************
   // Flags and interrupt
   // *************************************************************
   // Hardware set wins over a write-one clear in the same cycle
   always_comb begin
      ccf_next = ccf_reg;
      if (wrEv && idx == IDX_STAT) begin
         ccf_next = ccf_reg & ~wd8[NMOD-1:0];
      end
      for (int n = 0; n < NMOD; n++) begin
         if (capEv[n] || (matchEv[n] && mode_reg[n].matchFlagEnable)) begin
            ccf_next[n] = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ccf_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         ccf_reg <= ccf_next;
         irq_reg <= |(ccf_reg & {mode_reg[2].flagIrqEnable, mode_reg[1].flagIrqEnable,
                                 mode_reg[0].flagIrqEnable});
      end
   end

   // *************************************************************
   // Output pins and watchdog
   // *************************************************************
   // PWM needs compare enable; frequency and toggle flip on matches
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_reg <= '0;
      end else begin
         for (int n = 0; n < NMOD; n++) begin
            if (active[n] && mode_reg[n].pulseModEnable && !mode_reg[n].toggleEnable
                && mode_reg[n].compareEnable) begin
               pin_reg[n] <= pwmLevel[n];
            end else if (matchEv[n] && mode_reg[n].toggleEnable) begin
               pin_reg[n] <= ~pin_reg[n];
            end
         end
      end
   end

   // Watchdog expiry: one pulse when counter reaches module two value
   assign wdHit = wdOn & (cnt_reg == cmp_reg[WDOG_MODULE]) & ~wdPrev_reg;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wdPrev_reg <= 1'b0;
         wdt_reg <= 1'b0;
      end else begin
         wdPrev_reg <= cnt_reg == cmp_reg[WDOG_MODULE];
         wdt_reg <= wdHit;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign moduleOutputPin = pin_reg;
   assign irq = irq_reg;
   assign wdtExpire = wdt_reg;

   // *************************************************************
   // Assertions
   // *************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_mode_two_lock: assert property (wdOn && wrEv && idx == IDX_MODE[2] |=> $stable(mode_reg[2]))
      else $error("Module two mode changed under watchdog");
   a_cnt_low_lock: assert property (wdOn && wrEv && idx == IDX_CNTL && !cntRun |=> $stable(cnt_reg))
      else $error("Counter low byte written under watchdog");
   a_cnt_low_write: assert property (!wdOn && wrEv && idx == IDX_CNTL |=> cnt_reg[7:0] == $past(wd8))
      else $error("Counter low byte write lost");
   a_ecom_clear: assert property (wrEv && idx == IDX_CMPL[0] |=> !mode_reg[0].compareEnable)
      else $error("Compare low write left compare enabled");
   a_ecom_set: assert property (wrEv && idx == IDX_CMPH[0] |=> mode_reg[0].compareEnable)
      else $error("Compare high write left compare disabled");
   a_capture_copy: assert property (capEv[0] |=> cmp_reg[0] == $past(cnt_reg) && ccf_reg[0])
      else $error("Capture did not copy counter and set flag");
   a_match_flag: assert property (matchEv[1] && mode_reg[1].matchFlagEnable |=> ccf_reg[1])
      else $error("Match did not set flag");
   a_toggle_pin: assert property (matchEv[1] && mode_reg[1].toggleEnable && !mode_reg[1].pulseModEnable
      |=> pin_reg[1] != $past(pin_reg[1]))
      else $error("Toggle match did not invert pin");
   a_irq_gate: assert property (ccf_reg[0] && mode_reg[0].flagIrqEnable |=> irq_reg)
      else $error("Enabled flag raised no interrupt");
   a_irq_quiet: assert property (!(|(ccf_reg & {mode_reg[2].flagIrqEnable, mode_reg[1].flagIrqEnable,
      mode_reg[0].flagIrqEnable})) |=> !irq_reg)
      else $error("Interrupt without enabled flag");
   a_snap_read: assert property (setupPh && !apbReq.pwrite && idx == IDX_CNTL
      |=> snap_reg == $past(cnt_reg[15:8]))
      else $error("Low byte read did not snapshot high byte");
endmodule
`default_nettype wire

// file: cca_pkg.sv
// Package: register map, mode fields and bus carrier of the counter array mode control
package cca_pkg;
   // *************************************************************
   // Structure
   // *************************************************************
   localparam int NMOD = 3;
   localparam int WDOG_MODULE = 2;
   localparam int ADDR_W = 12;
   // *************************************************************
   // Register indices (byte address = 4 * index)
   // *************************************************************
   localparam logic [2:0][7:0] IDX_MODE = {8'hDC, 8'hDB, 8'hDA};
   localparam logic [2:0][7:0] IDX_CMPL = {8'hEB, 8'hE9, 8'hFB};
   localparam logic [2:0][7:0] IDX_CMPH = {8'hEC, 8'hEA, 8'hFC};
   localparam logic [7:0] IDX_CNTL = 8'hF9;
   localparam logic [7:0] IDX_CNTH = 8'hFA;
   localparam logic [7:0] IDX_PWMCFG = 8'hF7;
   localparam logic [7:0] IDX_CTRL = 8'hD9;
   localparam logic [7:0] IDX_STAT = 8'hD8;
   localparam logic [7:0] IDX_MASK = 8'hD7;
   // *************************************************************
   // Field positions and reset values
   // *************************************************************
   localparam int CTRL_WATCHDOG_ENABLE_BIT_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CMP_RST = 16'h0000;
   localparam logic [1:0] CYCLE_LENGTH_SELECT_RST = 2'h0;
   localparam logic [15:0] BASE_MASK = 16'h00FF;
   localparam logic [15:0] FULL_MASK = 16'hFFFF;
   // *************************************************************
   // Types
   // *************************************************************
   typedef struct packed {
      logic wideCycleSelect;
      logic compareEnable;
      logic riseCaptureEnable;
      logic fallCaptureEnable;
      logic matchFlagEnable;
      logic toggleEnable;
      logic pulseModEnable;
      logic flagIrqEnable;
   } cca_mode_s;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } cca_apb_req_s;
endpackage

// file: cca_edge_sync.sv
// Two-stage synchroniser with registered rise and fall pulses
`timescale 1ns/1ps
`default_nettype none
module cca_edge_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_reg, sync_reg, last_reg, rise_reg, fall_reg;
   // *************************************************************
   // Synchroniser: meta_reg feeds only sync_reg
   // *************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end else begin
         meta_reg <= din;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end
   // Edge pulses from settled samples only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rise_reg <= '0;
         fall_reg <= '0;
      end else begin
         rise_reg <= sync_reg & ~last_reg;
         fall_reg <= ~sync_reg & last_reg;
      end
   end
   assign rise = rise_reg;
   assign fall = fall_reg;
endmodule
`default_nettype wire

// file: cca_pin_model.sv
// Pin-side partner model: drives the capture inputs of the three modules
`timescale 1ns/1ps
`default_nettype none
module cca_pin_model (
   input wire logic core_clk,
   output logic [cca_pkg::NMOD-1:0] edgeIn
);
   import cca_pkg::*;
   // *************************************************************
   // Input pin drive
   // *************************************************************
   // All inputs idle low from time zero
   initial edgeIn = '0;
   // Move one pin just after an edge, then hold it so the level survives the
   // two-flop synchroniser; a shorter glitch could be missed by the device
   task automatic drive(input int ch, input logic lvl);
      @(posedge core_clk);
      edgeIn[ch] <= lvl;
      repeat (6) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the counter array mode control
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] %0t got %0h want %0h", $time, got, exp); end end
module testbench;
   import cca_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   cca_apb_req_s req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, wdtExpire;
   logic [NMOD-1:0] edgeIn, pins;
   logic [7:0] rd;
   logic err, p0;
   logic [15:0] m;
   int error_cnt = 0;
   int total_checks = 0;
   int n;
   // *************************************************************
   // Clock, design and pin model
   // *************************************************************
   // 20 MHz core clock
   always #25 core_clk = ~core_clk;
   cca_mode_ctrl u_dut (.core_clk(core_clk), .rstn(rstn), .apbReq(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .edgeIn(edgeIn), .moduleOutputPin(pins), .irq(irq), .wdtExpire(wdtExpire));
   cca_pin_model u_pins (.core_clk(core_clk), .edgeIn(edgeIn));
   // *************************************************************
   // Tasks
   // *************************************************************
   // Verdict and end of run
   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // A wait that ran out of cycles ends the run as a mismatch
   task automatic too_long();
      error_cnt++;
      $display("[ERR] %0t wait timed out", $time);
      results();
   endtask
   // One APB transfer; the request is held until pready is seen at an edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      int k;
      @(posedge core_clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= {2'b00, idx, 2'b00};
      req.pwdata <= {24'h000000, wd};
      @(posedge core_clk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) too_long();
      rd = prdata[7:0];
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      xfer(1'b1, idx, wd);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      `CHK(rd, exp)
   endtask
   // Cycles until the module pin changes level
   task automatic wait_pin(input int ch, output int cyc);
      logic p;
      p = pins[ch];
      cyc = 0;
      do begin
         @(posedge core_clk);
         cyc++;
      end while (pins[ch] === p && cyc < 400);
      if (pins[ch] === p) too_long();
   endtask
   // Cycles until the watchdog expiry pulse is seen
   task automatic wait_wdt(output int cyc);
      cyc = 0;
      do begin
         @(posedge core_clk);
         cyc++;
      end while (wdtExpire !== 1'b1 && cyc < 200);
      if (wdtExpire !== 1'b1) too_long();
   endtask
   task automatic wait_irq();
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 30) begin
         @(posedge core_clk);
         k++;
      end
      if (irq !== 1'b1) too_long();
   endtask
   // *************************************************************
   // Main sequence
   // *************************************************************
   initial begin
      repeat (10) @(posedge core_clk);
      `CHK(pins, 3'h0)
      `CHK(irq, 1'b0)
      rstn <= 1'b1;
      for (int i = 0; i < NMOD; i++) rdchk(IDX_MODE[i], MODE_RST);
      rdchk(IDX_CNTL, 8'h00);
      `CHK(err, 1'b0)
      // Unmapped index is refused
      xfer(1'b0, 8'h00, 8'h00);
      `CHK(err, 1'b1)
      `CHK(rd, 8'h00)
      // Counter bytes and high byte snapshot
      wr(IDX_CNTH, 8'h01);
      wr(IDX_CNTL, 8'h50);
      rdchk(IDX_CNTL, 8'h50);
      rdchk(IDX_CNTH, 8'h01);
      wr(IDX_CNTH, 8'h02);
      rdchk(IDX_CNTH, 8'h01);
      rdchk(IDX_CNTL, 8'h50);
      rdchk(IDX_CNTH, 8'h02);
      // Compare byte writes move the compare enable bit
      wr(IDX_MODE[1], 8'hFF);
      rdchk(IDX_MODE[1], 8'hFF);
      wr(IDX_CMPL[1], 8'h40);
      rdchk(IDX_MODE[1], 8'hBF);
      wr(IDX_CMPH[1], 8'h00);
      rdchk(IDX_MODE[1], 8'hFF);
      wr(IDX_MODE[1], 8'h00);
      // Watchdog on locks module two mode and the counter low byte
      wr(IDX_CTRL, 8'h01);
      wr(IDX_MODE[2], 8'h55);
      rdchk(IDX_MODE[2], 8'h00);
      wr(IDX_CNTL, 8'h11);
      rdchk(IDX_CNTL, 8'h50);
      wr(IDX_CTRL, 8'h00);
      wr(IDX_MODE[2], 8'h55);
      rdchk(IDX_MODE[2], 8'h55);
      wr(IDX_MODE[2], 8'h00);
      // Capture on edges of module zero's input, counter held at 0x0250
      wr(IDX_MODE[0], 8'h21);
      u_pins.drive(0, 1'b1);
      wait_irq();
      `CHK(irq, 1'b1)
      rdchk(IDX_STAT, 8'h01);
      rdchk(IDX_CMPL[0], 8'h50);
      rdchk(IDX_CMPH[0], 8'h02);
      wr(IDX_STAT, 8'h01);
      u_pins.drive(0, 1'b0);
      rdchk(IDX_STAT, 8'h00);
      wr(IDX_MODE[0], 8'h31);
      u_pins.drive(0, 1'b1);
      wait_irq();
      wr(IDX_STAT, 8'h01);
      u_pins.drive(0, 1'b0);
      rdchk(IDX_STAT, 8'h01);
      wr(IDX_MASK, 8'h00);
      rdchk(IDX_STAT, 8'h01);
      `CHK(irq, 1'b0)
      wr(IDX_STAT, 8'h07);
      // PWM over every cycle length code, then wide, counter 0x0950 against 0x0280
      wr(IDX_CNTH, 8'h09);
      wr(IDX_CMPL[0], 8'h80);
      wr(IDX_CMPH[0], 8'h02);
      wr(IDX_MODE[0], 8'h42);
      for (int k = 0; k < 4; k++) begin
         wr(IDX_PWMCFG, k[7:0]);
         rdchk(IDX_CNTL, 8'h50);
         m = (16'h0001 << (8 + k)) - 16'h0001;
         `CHK(pins[0], (16'h0950 & m) >= (16'h0280 & m))
      end
      wr(IDX_MODE[0], 8'hC2);
      rdchk(IDX_CNTL, 8'h50);
      `CHK(pins[0], 1'b1)
      wr(IDX_MODE[0], 8'h00);
      // Match sets the flag and toggles the pin once, compare at 0x0040
      wr(IDX_CMPL[1], 8'h40);
      wr(IDX_CMPH[1], 8'h00);
      wr(IDX_CNTH, 8'h00);
      wr(IDX_CNTL, 8'h3F);
      wr(IDX_MODE[1], 8'h4C);
      p0 = pins[1];
      wr(IDX_CTRL, 8'h02);
      wait_pin(1, n);
      `CHK(pins[1], ~p0)
      rdchk(IDX_STAT, 8'h02);
      // Frequency output: half period equals the compare high byte
      wr(IDX_MODE[1], 8'h00);
      wr(IDX_CMPL[1], 8'h20);
      wr(IDX_CMPH[1], 8'h10);
      wr(IDX_MODE[1], 8'h46);
      wait_pin(1, n);
      wait_pin(1, n);
      `CHK(n, 16)
      wr(IDX_CTRL, 8'h00);
      // Watchdog expiry: counter from zero meets module two compare 0x0030
      wr(IDX_CNTH, 8'h00);
      wr(IDX_CNTL, 8'h00);
      wr(IDX_CMPL[2], 8'h30);
      wr(IDX_CMPH[2], 8'h00);
      wr(IDX_CTRL, 8'h03);
      wait_wdt(n);
      `CHK(n, 50)
      @(posedge core_clk);
      `CHK(wdtExpire, 1'b0)
      wr(IDX_CTRL, 8'h00);
      results();
   end
endmodule
`default_nettype wire
